/* qaw_device.sv */
// qaw_device: question-and-answer watchdog with its register file.
// assumes the host holds each link request until done, then drops it.
`timescale 1ns/1ns

// How it works
// - four ordered, timed bytes form one answer
// - each window is half the period
// - reading the question starts the timer
// - host writes three bytes in window one
// - host writes last byte in window two
// - good answer gives new question, new cycle
// - last byte ends window two at once
// - bad answer keeps question, bumps error count
// - error count at threshold fires failure action
// - answers may come without reading the question
// - new question one clock after last byte
// - link traffic other than cfg1 or cfg2 writes never disturbs evaluation
// - readable four-bit question from generator
// - generator steps only on a good answer
// - zero generator state is forced to one
// - one answer register, index three down to zero
// - default answers follow the fixed table
// - host should pick periods above 64 ms
// - register sets failure reset pulse width
// - error count up on bad, down on good
// - two-bit mode field selects watchdog type
// - period from prescaler and timer lookup
module qaw_device #(
    parameter int unsigned MS_CYCLES = qaw_pkg::MS_CYCLES_DEF
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    qaw_link_if.dev link,
    output logic fail_irq_o,
    output logic fail_rst_o,
    output logic [3:0] question_o
);
    // link domain
    logic rst_l1, rst_l2;
    logic req_l1, req_l2;
    logic ack_l1, ack_l2, ack_l3;
    logic lk_busy, next_lk_busy;
    logic lk_done, next_lk_done;
    logic lk_tgl, next_lk_tgl;
    logic lk_wr, next_lk_wr;
    logic [7:0] lk_addr, next_lk_addr;
    logic [7:0] lk_wdata, next_lk_wdata;
    logic [7:0] lk_rdata, next_lk_rdata;

    assign link.done = lk_done;
    assign link.rdata = lk_rdata;

    // system domain
    logic req_s1, req_s2, req_s3;
    logic ack_tgl, next_ack_tgl;
    logic [7:0] rdata, next_rdata;
    logic [7:0] cfg1, next_cfg1;
    logic [2:0] tmr, next_tmr;
    logic [7:0] rstw, next_rstw;
    logic [7:0] qacfg, next_qacfg;
    qaw_pkg::qaw_win_t win, next_win;
    logic [31:0] ms_cnt, next_ms_cnt;
    logic [15:0] win_ms, next_win_ms;
    logic [1:0] idx, next_idx;
    logic bad, next_bad;
    logic [3:0] err, next_err;
    logic [7:0] pulse_ms, next_pulse_ms;
    logic next_fail_irq, next_fail_rst;
    logic [3:0] next_question;

    always_comb begin
        next_lk_busy = lk_busy;
        next_lk_done = lk_done;
        next_lk_tgl = lk_tgl;
        next_lk_wr = lk_wr;
        next_lk_addr = lk_addr;
        next_lk_wdata = lk_wdata;
        next_lk_rdata = lk_rdata;
        if (req_l2 && !lk_busy) begin
            next_lk_busy = 1'b1;
            next_lk_tgl = ~lk_tgl;
            next_lk_wr = link.wr;
            next_lk_addr = link.addr;
            next_lk_wdata = link.wdata;
        end
        // system side has answered; its read data is stable now
        if (lk_busy && !lk_done && (ack_l2 != ack_l3)) begin
            next_lk_done = 1'b1;
            next_lk_rdata = rdata;
        end
        if (lk_done && !req_l2) begin
            next_lk_done = 1'b0;
            next_lk_busy = 1'b0;
        end
    end

    always_ff @(posedge link.link_clk) begin
        rst_l1 <= sys_rst_i;
        rst_l2 <= rst_l1;
        req_l1 <= link.req;
        req_l2 <= req_l1;
        ack_l1 <= ack_tgl;
        ack_l2 <= ack_l1;
        ack_l3 <= ack_l2;
        if (rst_l2) begin
            lk_busy <= 1'b0;
            lk_done <= 1'b0;
            lk_tgl <= 1'b0;
            lk_wr <= 1'b0;
            lk_addr <= 8'h00;
            lk_wdata <= 8'h00;
            lk_rdata <= 8'h00;
        end else begin
            lk_busy <= next_lk_busy;
            lk_done <= next_lk_done;
            lk_tgl <= next_lk_tgl;
            lk_wr <= next_lk_wr;
            lk_addr <= next_lk_addr;
            lk_wdata <= next_lk_wdata;
            lk_rdata <= next_lk_rdata;
        end
    end

    always_comb begin
        logic req_new;
        logic ans_wr;
        logic q_rd;
        logic qa_on;
        logic ms_tick;
        logic win_end;
        logic finish;
        logic fin_bad;
        logic [15:0] half;
        logic [3:0] err_up;
        logic fire;
        req_new = req_s2 ^ req_s3;
        ans_wr = req_new && lk_wr && (lk_addr == qaw_pkg::ADDR_ANS);
        q_rd = req_new && !lk_wr && (lk_addr == qaw_pkg::ADDR_QUEST);
        // period from scale and base fields
        half = qaw_pkg::qaw_period_ms(cfg1[qaw_pkg::CFG1_PRE_LSB +: 2],
                                      tmr) >> 1;
        // only the question-and-answer mode runs here
        qa_on = (cfg1[qaw_pkg::CFG1_MODE_LSB +: 2] == qaw_pkg::MODE_QA) &&
                (half != 16'h0000);
        ms_tick = (ms_cnt == 32'(MS_CYCLES - 1));
        win_end = ms_tick && ((win_ms + 16'h0001) == half);
        finish = 1'b0;
        fin_bad = bad;
        err_up = err;
        fire = 1'b0;
        next_ack_tgl = ack_tgl;
        next_rdata = rdata;
        next_cfg1 = cfg1;
        next_tmr = tmr;
        next_rstw = rstw;
        next_qacfg = qacfg;
        next_win = win;
        next_ms_cnt = ms_tick ? 32'h0 : ms_cnt + 32'h1;
        next_win_ms = ms_tick ? win_ms + 16'h0001 : win_ms;
        next_idx = idx;
        next_bad = bad;
        next_err = err;
        next_pulse_ms = pulse_ms;
        next_fail_irq = 1'b0;
        next_fail_rst = fail_rst_o;
        next_question = question_o;
        // any transfer is answered, undecoded addresses read zero
        if (req_new) begin
            next_ack_tgl = ~ack_tgl;
            next_rdata = 8'h00;
            if (lk_wr) begin
                case (lk_addr)
                    qaw_pkg::ADDR_CFG1: next_cfg1 = lk_wdata;
                    qaw_pkg::ADDR_CFG2:
                        next_tmr = lk_wdata[qaw_pkg::CFG2_TMR_LSB +: 3];
                    qaw_pkg::ADDR_RSTW: next_rstw = lk_wdata;
                    qaw_pkg::ADDR_QACFG: next_qacfg = lk_wdata;
                    default: next_rdata = 8'h00;
                endcase
            end else begin
                case (lk_addr)
                    qaw_pkg::ADDR_CFG1: next_rdata = cfg1;
                    qaw_pkg::ADDR_CFG2: next_rdata = {tmr, 1'b0, err};
                    qaw_pkg::ADDR_RSTW: next_rdata = rstw;
                    qaw_pkg::ADDR_QACFG: next_rdata = qacfg;
                    qaw_pkg::ADDR_QUEST: next_rdata = {4'h0, question_o};
                    default: next_rdata = 8'h00;
                endcase
            end
        end
        case (win)
            qaw_pkg::QAW_IDLE: begin
                next_ms_cnt = 32'h0;
                next_win_ms = 16'h0000;
                // question read starts the cycle timer
                // an answer byte may start it too
                if (qa_on && (q_rd || ans_wr)) begin
                    next_win = qaw_pkg::QAW_WIN1;
                    next_idx = qaw_pkg::ANS_FIRST;
                    next_bad = 1'b0;
                end
            end
            qaw_pkg::QAW_WIN1: begin
                if (win_end) begin
                    next_win = qaw_pkg::QAW_WIN2;
                    next_win_ms = 16'h0000;
                end
            end
            qaw_pkg::QAW_WIN2: begin
                // a missing last byte counts as bad
                if (win_end) begin
                    finish = 1'b1;
                    fin_bad = 1'b1;
                end
            end
            default: begin
                next_win = qaw_pkg::QAW_IDLE;
            end
        endcase
        if (ans_wr && qa_on) begin
            // single register, index 3 down to 0
            // check byte then step the index
            if (lk_wdata != qaw_pkg::qaw_answer(question_o, idx)) begin
                next_bad = 1'b1;
                fin_bad = 1'b1;
            end
            if (idx != qaw_pkg::ANS_LAST) begin
                next_idx = idx - 2'h1;
            end
            // fourth byte in window one is mistimed
            if ((win != qaw_pkg::QAW_WIN2) && (idx == qaw_pkg::ANS_LAST)) begin
                next_bad = 1'b1;
            end
            if (win == qaw_pkg::QAW_WIN2) begin
                // the last byte closes window two
                if (idx == qaw_pkg::ANS_LAST) begin
                    finish = 1'b1;
                end else begin
                    next_bad = 1'b1;
                end
            end
        end
        if (finish) begin
            next_win = qaw_pkg::QAW_WIN1;
            next_ms_cnt = 32'h0;
            next_win_ms = 16'h0000;
            next_idx = qaw_pkg::ANS_FIRST;
            next_bad = 1'b0;
            if (!fin_bad) begin
                // good answer, new question and cycle
                // question changes on this same edge
                // generator steps on a good answer only
                // zero state is forced to one
                next_question = qaw_pkg::qaw_next_q(question_o);
                if (err != 4'h0) begin
                    next_err = err - 4'h1;
                end
            end else begin
                if (err != qaw_pkg::ERR_MAX) begin
                    err_up = err + 4'h1;
                end
                next_err = err_up;
                if (err_up >= qaw_pkg::qaw_threshold(
                        cfg1[qaw_pkg::CFG1_THR_LSB +: 2])) begin
                    fire = 1'b1;
                    next_fail_irq = cfg1[qaw_pkg::CFG1_ACT_LSB];
                    if (cfg1[qaw_pkg::CFG1_ACT_LSB + 1]) begin
                        next_fail_rst = 1'b1;
                        next_pulse_ms = rstw;
                    end
                end
            end
        end
        // reset pulse lasts rstw+1 ms ticks
        // a fresh failure action reloads the width, never counts down
        if (fail_rst_o && ms_tick && !fire) begin
            if (pulse_ms == 8'h00) begin
                next_fail_rst = 1'b0;
            end else begin
                next_pulse_ms = pulse_ms - 8'h01;
            end
        end
        if (!qa_on) begin
            next_win = qaw_pkg::QAW_IDLE;
        end
    end

    always_ff @(posedge clk_i) begin
        req_s1 <= lk_tgl;
        req_s2 <= req_s1;
        req_s3 <= req_s2;
        if (sys_rst_i) begin
            ack_tgl <= 1'b0;
            rdata <= 8'h00;
            cfg1 <= qaw_pkg::CFG1_RST;
            tmr <= qaw_pkg::TMR_RST;
            rstw <= qaw_pkg::RSTW_RST;
            qacfg <= qaw_pkg::QACFG_RST;
            win <= qaw_pkg::QAW_IDLE;
            ms_cnt <= 32'h0;
            win_ms <= 16'h0000;
            idx <= qaw_pkg::ANS_FIRST;
            bad <= 1'b0;
            err <= 4'h0;
            pulse_ms <= 8'h00;
            fail_irq_o <= 1'b0;
            fail_rst_o <= 1'b0;
            question_o <= qaw_pkg::QUEST_RST;
        end else begin
            ack_tgl <= next_ack_tgl;
            rdata <= next_rdata;
            cfg1 <= next_cfg1;
            tmr <= next_tmr;
            rstw <= next_rstw;
            qacfg <= next_qacfg;
            win <= next_win;
            ms_cnt <= next_ms_cnt;
            win_ms <= next_win_ms;
            idx <= next_idx;
            bad <= next_bad;
            err <= next_err;
            pulse_ms <= next_pulse_ms;
            fail_irq_o <= next_fail_irq;
            fail_rst_o <= next_fail_rst;
            question_o <= next_question;
        end
    end
endmodule // qaw_device

/* qaw_pkg.sv */
// qaw_pkg: constants, types and decode functions for the Q&A watchdog.
// assumes both link ends and the watchdog core refer to it by qaw_pkg:: names.
package qaw_pkg;

    // register offsets
    localparam logic [7:0] ADDR_CFG1 = 8'h13;
    localparam logic [7:0] ADDR_CFG2 = 8'h14;
    localparam logic [7:0] ADDR_TRIG = 8'h15;
    localparam logic [7:0] ADDR_RSTW = 8'h16;
    localparam logic [7:0] ADDR_QACFG = 8'h2D;
    localparam logic [7:0] ADDR_ANS = 8'h2E;
    localparam logic [7:0] ADDR_QUEST = 8'h2F;

    // values after reset
    localparam logic [7:0] CFG1_RST = 8'h00;
    localparam logic [2:0] TMR_RST = 3'h0;
    localparam logic [7:0] RSTW_RST = 8'h00;
    localparam logic [7:0] QACFG_RST = 8'h00;
    localparam logic [3:0] QUEST_RST = 4'h0;

    // field positions
    localparam int CFG1_MODE_LSB = 6;
    localparam int CFG1_PRE_LSB = 4;
    localparam int CFG1_THR_LSB = 2;
    localparam int CFG1_ACT_LSB = 0;
    localparam int CFG2_TMR_LSB = 5;

    localparam logic [1:0] MODE_QA = 2'h3;
    localparam logic [1:0] ANS_FIRST = 2'h3;
    localparam logic [1:0] ANS_LAST = 2'h0;
    localparam logic [3:0] ERR_MAX = 4'hF;

    // timing
    localparam int CLK_HZ = 50000000;
    localparam int MS_PER_S = 1000;
    localparam int MS_CYCLES_DEF = CLK_HZ / MS_PER_S;

    typedef enum logic [1:0] {
        QAW_IDLE = 2'b00,
        QAW_WIN1 = 2'b01,
        QAW_WIN2 = 2'b10
    } qaw_win_t;

    typedef enum logic [1:0] {
        QAW_H_IDLE = 2'b00,
        QAW_H_REQ = 2'b01,
        QAW_H_WAIT = 2'b10
    } qaw_host_t;

    // total period in ms; zero marks a reserved combination
    function automatic logic [15:0] qaw_period_ms(input logic [1:0] pre,
                                                  input logic [2:0] tmr);
        logic [15:0] p;
        p = 16'h0000;
        case ({tmr, pre})
            5'b000_00: p = 16'd4;
            5'b000_01: p = 16'd8;
            5'b000_10: p = 16'd12;
            5'b000_11: p = 16'd16;
            5'b001_00: p = 16'd32;
            5'b001_01: p = 16'd64;
            5'b001_10: p = 16'd96;
            5'b001_11: p = 16'd128;
            5'b010_00: p = 16'd128;
            5'b010_01: p = 16'd256;
            5'b010_10: p = 16'd384;
            5'b010_11: p = 16'd512;
            5'b011_00: p = 16'd256;
            5'b011_01: p = 16'd384;
            5'b011_10: p = 16'd512;
            5'b011_11: p = 16'd768;
            5'b100_00: p = 16'd512;
            5'b100_01: p = 16'd1024;
            5'b100_10: p = 16'd1536;
            5'b100_11: p = 16'd2048;
            5'b101_00: p = 16'd2048;
            5'b101_01: p = 16'd4096;
            5'b101_10: p = 16'd6144;
            5'b101_11: p = 16'd8192;
            5'b110_00: p = 16'd10240;
            5'b110_01: p = 16'd20240;
            default: p = 16'h0000;
        endcase
        return p;
    endfunction

    // error count at which the failure action fires
    function automatic logic [3:0] qaw_threshold(input logic [1:0] sel);
        logic [3:0] t;
        case (sel)
            2'h0: t = 4'h1;
            2'h1: t = 4'h5;
            default: t = 4'h9;
        endcase
        return t;
    endfunction

    // question generator step; all zeros is forced out
    function automatic logic [3:0] qaw_next_q(input logic [3:0] q);
        logic [3:0] n;
        n = {q[2:0], q[3] ^ q[2]};
        if (q == 4'h0) begin
            n = 4'h1;
        end
        return n;
    endfunction

    // expected byte for a question and answer index, default settings
    function automatic logic [7:0] qaw_answer(input logic [3:0] q,
                                              input logic [1:0] idx);
        logic [31:0] a;
        case (q)
            4'h0: a = 32'hFF0FF000;
            4'h1: a = 32'hB040BF4F;
            4'h2: a = 32'hE919E616;
            4'h3: a = 32'hA656A959;
            4'h4: a = 32'h75857A8A;
            4'h5: a = 32'h3ACA35C5;
            4'h6: a = 32'h63936C9C;
            4'h7: a = 32'h2CDC23D3;
            4'h8: a = 32'hD222DD2D;
            4'h9: a = 32'h9D6D9262;
            4'hA: a = 32'hC434CB3B;
            4'hB: a = 32'h8B7B8474;
            4'hC: a = 32'h58A857A7;
            4'hD: a = 32'h17E718E8;
            4'hE: a = 32'h4EBE41B1;
            default: a = 32'h01F10EFE;
        endcase
        return a[{idx, 3'b000} +: 8];
    endfunction

endpackage

/* qaw_link_if.sv */
// qaw_link_if: register link between the host end and the watchdog.
// assumes the host drives link_clk and holds addr/wr/wdata while req.
`timescale 1ns/1ns
interface qaw_link_if;
    logic link_clk;
    logic req;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic done;
    logic [7:0] rdata;

    modport dev (
        input link_clk,
        input req,
        input wr,
        input addr,
        input wdata,
        output done,
        output rdata
    );

    modport host (
        output link_clk,
        output req,
        output wr,
        output addr,
        output wdata,
        input done,
        input rdata
    );
endinterface

/* qaw_host.sv */
// qaw_host: host end; turns user commands into link transfers.
// assumes one command at a time; link_clk is clk_i divided by two.
`timescale 1ns/1ns
module qaw_host (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    qaw_link_if.host link,
    input wire logic cmd_valid_i,
    input wire logic cmd_write_i,
    input wire logic [7:0] cmd_addr_i,
    input wire logic [7:0] cmd_wdata_i,
    output logic cmd_ready_o,
    output logic rsp_valid_o,
    output logic [7:0] rsp_rdata_o
);
    qaw_pkg::qaw_host_t state, next_state;
    logic lclk, next_lclk;
    logic h_req, next_h_req;
    logic h_wr, next_h_wr;
    logic [7:0] h_addr, next_h_addr;
    logic [7:0] h_wdata, next_h_wdata;
    logic next_cmd_ready;
    logic next_rsp_valid;
    logic [7:0] next_rsp_rdata;
    logic done_s1, done_s2;
    logic rst_seen;

    assign link.link_clk = lclk;
    assign link.req = h_req;
    assign link.wr = h_wr;
    assign link.addr = h_addr;
    assign link.wdata = h_wdata;

    always_comb begin
        next_state = state;
        // slow link, several cycles per byte
        next_lclk = ~lclk;
        next_h_req = h_req;
        next_h_wr = h_wr;
        next_h_addr = h_addr;
        next_h_wdata = h_wdata;
        next_rsp_valid = 1'b0;
        next_rsp_rdata = rsp_rdata_o;
        // link outputs only move as link_clk falls
        case (state)
            qaw_pkg::QAW_H_IDLE: begin
                // final byte goes when user sends it
                if (cmd_valid_i && cmd_ready_o) begin
                    next_h_req = 1'b1;
                    next_h_wr = cmd_write_i;
                    next_h_addr = cmd_addr_i;
                    next_h_wdata = cmd_wdata_i;
                    next_state = qaw_pkg::QAW_H_REQ;
                end
            end
            qaw_pkg::QAW_H_REQ: begin
                if (done_s2 && lclk) begin
                    next_h_req = 1'b0;
                    next_rsp_valid = 1'b1;
                    next_rsp_rdata = link.rdata;
                    next_state = qaw_pkg::QAW_H_WAIT;
                end
            end
            qaw_pkg::QAW_H_WAIT: begin
                if (!done_s2) begin
                    next_state = qaw_pkg::QAW_H_IDLE;
                end
            end
            default: begin
                next_state = qaw_pkg::QAW_H_IDLE;
            end
        endcase
        next_cmd_ready = (next_state == qaw_pkg::QAW_H_IDLE) && next_lclk;
    end

    always_ff @(posedge clk_i) begin
        done_s1 <= link.done;
        done_s2 <= done_s1;
        if (sys_rst_i) begin
            state <= qaw_pkg::QAW_H_IDLE;
            // link clock keeps running so the far end sees reset too
            if (rst_seen) begin
                lclk <= next_lclk;
            end else begin
                lclk <= 1'b0;
            end
            rst_seen <= 1'b1;
            h_req <= 1'b0;
            h_wr <= 1'b0;
            h_addr <= 8'h00;
            h_wdata <= 8'h00;
            cmd_ready_o <= 1'b0;
            rsp_valid_o <= 1'b0;
            rsp_rdata_o <= 8'h00;
        end else begin
            state <= next_state;
            lclk <= next_lclk;
            h_req <= next_h_req;
            h_wr <= next_h_wr;
            h_addr <= next_h_addr;
            h_wdata <= next_h_wdata;
            cmd_ready_o <= next_cmd_ready;
            rsp_valid_o <= next_rsp_valid;
            rsp_rdata_o <= next_rsp_rdata;
        end
    end
endmodule // qaw_host

/* qaw_link_monitor.sv */
// qaw_link_monitor: handshake and read-data checks on the register link.
// assumes the bench instantiates it beside the link interface.
`timescale 1ns/1ns
module qaw_link_monitor (
    input wire logic link_clk,
    input wire logic sys_rst_i,
    input wire logic req,
    input wire logic wr,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic done,
    input wire logic [7:0] rdata
);
    default clocking cb @(posedge link_clk); endclocking
    default disable iff (sys_rst_i);

    a_done_needs_req: assert property ($rose(done) |-> req)
        else $error("done rose without a request");
    a_req_held: assert property (req && !done |=> req)
        else $error("request dropped before done");
    a_fields_steady: assert property (req && done |->
        $stable(addr) && $stable(wdata) && $stable(wr))
        else $error("request fields moved during transfer");
    a_done_bounded: assert property ($rose(req) |-> ##[1:20] done)
        else $error("no done within bound");
    a_done_drops: assert property ($fell(req) |-> ##[1:6] !done)
        else $error("done stuck after request fell");
    a_quest_upper: assert property (done && !wr && addr == 8'h2F
        |-> rdata[7:4] == 4'h0)
        else $error("question read has upper bits set");
    a_answer_wo: assert property (done && !wr && addr == 8'h2E
        |-> rdata == 8'h00)
        else $error("answer register not write only");
    a_trig_reads0: assert property (done && !wr && addr == 8'h15
        |-> rdata == 8'h00)
        else $error("trigger register read not zero");

    cover property (done && wr && addr == 8'h2E);
    cover property (done && !wr && addr == 8'h2F);
    cover property ($fell(done));
endmodule // qaw_link_monitor

/* tb_question_answer_watchdog.sv */
// tb_question_answer_watchdog: host and device ends joined over the link.
// assumes MS_CYCLES of 10, so a 96 ms period is 960 clk_i cycles.
`timescale 1ns/1ns
module tb_question_answer_watchdog;
    logic clk_i, sys_rst_i, cmd_valid_i, cmd_write_i, cmd_ready_o;
    logic rsp_valid_o, fail_irq_o, fail_rst_o;
    logic [7:0] cmd_addr_i, cmd_wdata_i, rsp_rdata_o, rd;
    logic [3:0] question_o;
    int failures, n_tests, irqs, i;
    // rows: write flag, address, write data, expected read data
    logic [27:0] rows [17] = '{28'h0130000, 28'h0140000, 28'h0160000,
        28'h02D0000, 28'h02F0000, 28'h116A500, 28'h01600A5, 28'h12D3C00,
        28'h02D003C, 28'h1405500, 28'h0400000, 28'h1151200, 28'h0150000,
        28'h12E7700, 28'h02E0000, 28'h1149F00, 28'h0140080};
    logic [7:0] ans0 [3] = '{8'hFF, 8'h0F, 8'hF0};
    logic [7:0] ans1 [3] = '{8'hB0, 8'h40, 8'hBF};

    qaw_link_if link ();
    qaw_host i_qaw_host (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .link(link),
        .cmd_valid_i(cmd_valid_i), .cmd_write_i(cmd_write_i),
        .cmd_addr_i(cmd_addr_i), .cmd_wdata_i(cmd_wdata_i),
        .cmd_ready_o(cmd_ready_o), .rsp_valid_o(rsp_valid_o),
        .rsp_rdata_o(rsp_rdata_o));
    qaw_device #(.MS_CYCLES(10)) i_qaw_device (.clk_i(clk_i),
        .sys_rst_i(sys_rst_i), .link(link), .fail_irq_o(fail_irq_o),
        .fail_rst_o(fail_rst_o), .question_o(question_o));
    qaw_link_monitor i_qaw_link_monitor (.link_clk(link.link_clk),
        .sys_rst_i(sys_rst_i), .req(link.req), .wr(link.wr),
        .addr(link.addr), .wdata(link.wdata), .done(link.done),
        .rdata(link.rdata));

    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    always @(posedge clk_i) begin
        if (fail_irq_o === 1'b1) irqs++;
    end

    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        n_tests++;
        if (g !== e) begin
            failures++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    // one command, entered at a clock edge; response lands in rd
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [7:0] d);
        int k;
        k = 0;
        cmd_write_i <= w;
        cmd_addr_i <= a;
        cmd_wdata_i <= d;
        cmd_valid_i <= 1'b1;
        // outputs are looked at mid-cycle, where they are settled
        do @(negedge clk_i); while (cmd_ready_o !== 1'b1 && k++ < 100);
        @(posedge clk_i);
        cmd_valid_i <= 1'b0;
        do @(negedge clk_i); while (rsp_valid_o !== 1'b1 && k++ < 200);
        rd = rsp_rdata_o;
        @(posedge clk_i);
        if (k >= 200) failures++;
    endtask

    task automatic conclude;
        $display("checks=%0d errors=%0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // whole run needs about 2600 cycles
    initial begin
        repeat (20000) @(posedge clk_i);
        failures++;
        conclude();
    end

    initial begin
        sys_rst_i = 1'b1;
        cmd_valid_i = 1'b0;
        cmd_write_i = 1'b0;
        cmd_addr_i = 8'h00;
        cmd_wdata_i = 8'h00;
        repeat (4) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        @(posedge clk_i);
        chk({4'h0, question_o}, 8'h00);
        for (i = 0; i < 17; i++) begin
            xfer(rows[i][24], rows[i][23:16], rows[i][15:8]);
            if (!rows[i][24]) chk(rd, rows[i][7:0]);
        end
        xfer(1'b1, 8'h14, 8'h20);
        xfer(1'b1, 8'h13, 8'hE1);
        xfer(1'b0, 8'h2F, 8'h00);
        chk(rd, 8'h00);
        for (i = 0; i < 3; i++) xfer(1'b1, 8'h2E, ans0[i]);
        // wait past the 480-cycle first window
        repeat (420) @(posedge clk_i);
        xfer(1'b1, 8'h2E, 8'h00);
        chk({4'h0, question_o}, 8'h01);
        xfer(1'b0, 8'h14, 8'h00);
        chk(rd, 8'h20);
        // let the fresh cycle run out unanswered
        repeat (1000) @(posedge clk_i);
        xfer(1'b0, 8'h2F, 8'h00);
        chk(rd, 8'h01);
        xfer(1'b0, 8'h14, 8'h00);
        chk(rd, 8'h21);
        chk({7'h00, irqs > 0}, 8'h01);
        chk({7'h00, fail_rst_o}, 8'h00);
        // a good answer to question 1 steps on and counts back down
        for (i = 0; i < 3; i++) xfer(1'b1, 8'h2E, ans1[i]);
        repeat (320) @(posedge clk_i);
        xfer(1'b1, 8'h2E, 8'h4F);
        chk({4'h0, question_o}, 8'h02);
        xfer(1'b0, 8'h14, 8'h00);
        chk(rd, 8'h20);
        conclude();
    end
endmodule // tb_question_answer_watchdog
